/* File: shared/serial2_pkg.sv */
package serial2_pkg;

  // special function register addresses
  localparam logic [15:0] ASYNC_MODE_ADDR = 16'hFF70;
  localparam logic [15:0] RX_BUF_ADDR     = 16'hFF71;
  localparam logic [15:0] SYNC_MODE_ADDR  = 16'hFF72;
  localparam logic [15:0] BAUD_CTRL_ADDR  = 16'hFF73;
  localparam logic [15:0] SHIFT_DATA_ADDR = 16'hFF74;
  localparam logic [15:0] STATUS_ADDR     = 16'hFF75;

  // values after reset
  localparam logic [7:0]  REG_RESET       = 8'h00;

  // field positions
  localparam int CHAN_EN_BIT   = 7;
  localparam int ORDER_BIT     = 2;
  localparam int RXE_BIT       = 6;
  localparam int ERROR_IRQ_SUPPRESS_BIT      = 1;
  localparam int XFER_FLAG_BIT = 0;
  localparam int FRAME_ERR_BIT = 1;
  localparam int OVERRUN_BIT   = 2;
  localparam int TX_BUSY_BIT   = 3;
  localparam int RX_BUSY_BIT   = 4;

  // counts
  localparam logic [3:0] BITS_PER_XFER = 4'h8;
  localparam logic [3:0] LAST_BIT_IDX  = 4'h7;
  localparam logic [1:0] ERR_CPL_DELAY = 2'h2;
  localparam logic [1:0] OK_CPL_DELAY  = 2'h1;

  // baud generator codes
  localparam logic [4:0] DIV_BASE      = 5'h10;
  localparam logic [3:0] DIV_BYPASS    = 4'hF;
  localparam logic [3:0] PRE_CODE_N11  = 4'h0;
  localparam logic [3:0] PRE_CODE_N1   = 4'h5;
  localparam logic [3:0] PRE_CODE_N10  = 4'hE;
  localparam logic [9:0] PRE_MASK_N11  = 10'h3FF;

endpackage

/* File: core/baud_divider.sv */
`timescale 1ns/1ps
module baud_divider
  import serial2_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // control
  input  wire logic [7:0] baud_ctrl,
  input  wire logic       osc_mode,
  input  wire logic       restart,
  // ticks
  output logic            fsck_tick,
  output logic            half_tick
);

  typedef struct packed {
    logic       fxx_phase;
    logic [9:0] pre;
    logic [4:0] div;
  } baud_s;

  baud_s      st;
  baud_s      next_st;
  logic [3:0] prescale_select;
  logic [3:0] divisor_select;
  logic [9:0] pre_mask;
  logic       pre_ok;
  logic       fxx_en;
  logic [4:0] div_last;

  always_comb begin
    prescale_select = baud_ctrl[7:4];
    divisor_select  = baud_ctrl[3:0];
    // core clock is the oscillator, or half of it
    fxx_en = osc_mode | st.fxx_phase;
    pre_ok = 1'b1;
    if (prescale_select == PRE_CODE_N11) begin
      pre_mask = PRE_MASK_N11;
    end else if (prescale_select >= PRE_CODE_N1 &&
                 prescale_select <= PRE_CODE_N10) begin
      pre_mask = (10'h001 << (prescale_select - PRE_CODE_N1))
                 - 10'h001;
    end else begin
      // prohibited code: the source clock simply stops
      pre_mask = PRE_MASK_N11;
      pre_ok   = 1'b0;
    end
    fsck_tick = fxx_en && pre_ok && ((st.pre & pre_mask) == pre_mask);
    div_last  = DIV_BASE + {1'b0, divisor_select} - 5'h01;
    half_tick = fsck_tick && (divisor_select == DIV_BYPASS ||
                              st.div == div_last);
    next_st           = st;
    next_st.fxx_phase = ~st.fxx_phase;
    if (fxx_en) begin
      next_st.pre = st.pre + 10'h001;
    end
    if (half_tick) begin
      next_st.div = 5'h00;
    end else if (fsck_tick) begin
      next_st.div = st.div + 5'h01;
    end
    // realign so the first half period is a full one
    if (restart) begin
      next_st.pre = 10'h000;
      next_st.div = 5'h00;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

/* File: core/serial2_channel.sv */
`timescale 1ns/1ps
module serial2_channel
  import serial2_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // special function register access
  input  wire logic [15:0] sfr_addr,
  input  wire logic        sfr_we,
  input  wire logic        sfr_re,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  // clock mode from the oscillation mode register
  input  wire logic        oscillation_mode_bit,
  // three-wire pins
  output logic             serial_clock_pin,
  output logic             serial_out_pin,
  input  wire logic        serial_in_pin,
  // asynchronous receive pin
  input  wire logic        rxd_pin,
  // interrupt requests
  output logic             transfer_irq_flag,
  output logic             rx_complete_irq,
  output logic             rx_error_irq
);

  typedef enum logic {XFER_IDLE, XFER_SHIFT} xfer_state_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP}
    rx_state_e;

  typedef struct packed {
    logic [7:0]  baud_ctrl;
    logic [7:0]  sync_mode;
    logic [7:0]  async_mode;
    xfer_state_e xst;
    logic [7:0]  shreg;
    logic [3:0]  bitcnt;
    logic        sck;
    logic        so;
    logic        xfer_flag;
    rx_state_e   rx_shift_register;
    logic [7:0]  rx_sh;
    logic [3:0]  rx_cnt;
    logic        ph;
    logic [7:0]  receive_buffer;
    logic        rxb_full;
    logic        frame_err;
    logic        overrun_err;
    logic        err_flag;
    logic        pend;
    logic [1:0]  pend_cnt;
    logic        cpl_irq;
    logic        err_irq;
    logic        rxd_last;
    logic [7:0]  rdata;
    logic [1:0]  si_sync;
    logic [1:0]  rxd_sync;
  } chan_s;

  chan_s      st;
  chan_s      next_st;
  logic       fsck_tick;
  logic       half_tick;
  logic       restart;
  logic       chan_en;
  logic       lsb_first;
  logic       receive_enable_bit;
  logic       error_irq_suppress;
  logic       si;
  logic       rxd;
  logic       wr_shift;
  logic       start_xfer;
  logic       rx_start_edge;
  logic       rx_err;
  logic [7:0] wdata_rev;
  logic [7:0] shreg_rev;

  ////////////////////////////////////////////////////////////////////
  // decode

  assign chan_en   = st.sync_mode[CHAN_EN_BIT];
  assign lsb_first = st.sync_mode[ORDER_BIT];
  assign receive_enable_bit       = st.async_mode[RXE_BIT];
  assign error_irq_suppress      = st.async_mode[ERROR_IRQ_SUPPRESS_BIT];
  assign si        = st.si_sync[1];
  assign rxd       = st.rxd_sync[1];
  assign wr_shift  = sfr_we && sfr_addr == SHIFT_DATA_ADDR;
  // a write while busy or disabled never launches a transfer
  assign start_xfer = wr_shift && chan_en &&
                      st.xst == XFER_IDLE;
  assign rx_start_edge = receive_enable_bit && st.rx_shift_register == RX_IDLE &&
                         st.rxd_last && !rxd;
  assign restart   = start_xfer || rx_start_edge;
  assign rx_err    = !rxd || st.rxb_full;
  // reversal lives on the bus side only
  assign wdata_rev = {<<{sfr_wdata}};
  assign shreg_rev = {<<{st.shreg}};

  baud_divider u_baud (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .baud_ctrl (st.baud_ctrl),
    .osc_mode  (oscillation_mode_bit),
    .restart   (restart),
    .fsck_tick (fsck_tick),
    .half_tick (half_tick)
  );

  ////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st          = st;
    next_st.si_sync  = {st.si_sync[0], serial_in_pin};
    next_st.rxd_sync = {st.rxd_sync[0], rxd_pin};
    next_st.rxd_last = rxd;
    next_st.cpl_irq  = 1'b0;
    next_st.err_irq  = 1'b0;

    // register writes; baud control is not guarded while busy
    if (sfr_we && sfr_addr == BAUD_CTRL_ADDR) begin
      next_st.baud_ctrl = sfr_wdata;
    end
    if (sfr_we && sfr_addr == SYNC_MODE_ADDR) begin
      next_st.sync_mode = sfr_wdata;
    end
    if (sfr_we && sfr_addr == ASYNC_MODE_ADDR) begin
      next_st.async_mode = sfr_wdata;
    end
    if (sfr_we && sfr_addr == STATUS_ADDR &&
        !sfr_wdata[XFER_FLAG_BIT]) begin
      next_st.xfer_flag = 1'b0;
    end

    // reads; the data answer is registered
    if (sfr_re) begin
      unique case (sfr_addr)
        BAUD_CTRL_ADDR:  next_st.rdata = st.baud_ctrl;
        SYNC_MODE_ADDR:  next_st.rdata = st.sync_mode;
        ASYNC_MODE_ADDR: next_st.rdata = st.async_mode;
        SHIFT_DATA_ADDR: next_st.rdata = lsb_first ? shreg_rev
                                                   : st.shreg;
        RX_BUF_ADDR:     next_st.rdata = st.receive_buffer;
        STATUS_ADDR:     next_st.rdata = {3'h0,
                                          st.rx_shift_register != RX_IDLE,
                                          st.xst == XFER_SHIFT,
                                          st.overrun_err,
                                          st.frame_err,
                                          st.xfer_flag};
        default:         next_st.rdata = 8'h00;
      endcase
    end
    // an early buffer read drops the error that masked completion
    if (sfr_re && sfr_addr == RX_BUF_ADDR) begin
      next_st.rxb_full    = 1'b0;
      next_st.frame_err   = 1'b0;
      next_st.overrun_err = 1'b0;
      next_st.err_flag    = 1'b0;
    end

    // three-wire engine
    unique case (st.xst)
      XFER_IDLE: begin
        next_st.sck = 1'b1;
        if (wr_shift) begin
          next_st.shreg = lsb_first ? wdata_rev : sfr_wdata;
        end
        if (start_xfer) begin
          next_st.xst    = XFER_SHIFT;
          next_st.bitcnt = 4'h0;
        end
      end
      XFER_SHIFT: begin
        if (!chan_en) begin
          next_st.xst = XFER_IDLE;
          next_st.sck = 1'b1;
        end else if (half_tick) begin
          if (st.sck) begin
            next_st.sck   = 1'b0;
            next_st.so    = st.shreg[7];
            next_st.shreg = {st.shreg[6:0], 1'b0};
          end else begin
            next_st.sck      = 1'b1;
            next_st.shreg[0] = si;
            next_st.bitcnt   = st.bitcnt + 4'h1;
            if (st.bitcnt == LAST_BIT_IDX) begin
              next_st.xst       = XFER_IDLE;
              next_st.xfer_flag = 1'b1;
            end
          end
        end
      end
    endcase

    // completion request waits out the error window
    if (st.pend && fsck_tick) begin
      if (st.pend_cnt == OK_CPL_DELAY) begin
        next_st.pend    = 1'b0;
        next_st.cpl_irq = !(error_irq_suppress && next_st.err_flag);
      end else begin
        next_st.pend_cnt = st.pend_cnt - 2'h1;
      end
    end

    // asynchronous receiver, two half periods per bit
    unique case (st.rx_shift_register)
      RX_IDLE: begin
        if (rx_start_edge) begin
          next_st.rx_shift_register = RX_START;
        end
      end
      RX_START: begin
        if (half_tick) begin
          next_st.rx_shift_register    = rxd ? RX_IDLE : RX_DATA;
          next_st.ph     = 1'b0;
          next_st.rx_cnt = 4'h0;
        end
      end
      RX_DATA: begin
        if (half_tick) begin
          next_st.ph = ~st.ph;
          if (st.ph) begin
            next_st.rx_sh  = {rxd, st.rx_sh[7:1]};
            next_st.rx_cnt = st.rx_cnt + 4'h1;
            if (st.rx_cnt == LAST_BIT_IDX) begin
              next_st.rx_shift_register = RX_STOP;
            end
          end
        end
      end
      RX_STOP: begin
        if (half_tick) begin
          next_st.ph = ~st.ph;
          if (st.ph) begin
            next_st.rx_shift_register         = RX_IDLE;
            next_st.receive_buffer         = st.rx_sh;
            next_st.rxb_full    = 1'b1;
            next_st.frame_err   = !rxd;
            next_st.overrun_err = st.rxb_full;
            next_st.err_flag    = rx_err;
            next_st.err_irq     = rx_err;
            next_st.pend        = 1'b1;
            next_st.pend_cnt    = rx_err ? ERR_CPL_DELAY
                                         : OK_CPL_DELAY;
          end
        end
      end
    endcase

    // clearing receive enable: mid-frame keeps the old buffer,
    // after the load only the pending request is lost
    if (!receive_enable_bit) begin
      next_st.rx_shift_register     = RX_IDLE;
      next_st.pend    = 1'b0;
      // a completion already counted out is dropped with the enable
      next_st.cpl_irq = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st            <= '0;
      st.baud_ctrl  <= REG_RESET;
      st.sync_mode  <= REG_RESET;
      st.async_mode <= REG_RESET;
      st.sck        <= 1'b1;
      st.rxd_last   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // clock and data out to the peripheral, interrupt requests and read data
  assign serial_clock_pin  = st.sck;
  assign serial_out_pin    = st.so;
  assign transfer_irq_flag = st.xfer_flag;
  assign rx_complete_irq   = st.cpl_irq;
  assign rx_error_irq      = st.err_irq;
  assign sfr_rdata         = st.rdata;

  ////////////////////////////////////////////////////////////////////
  // checks

  logic [3:0] rise_cnt;
  logic       suppress;
  logic       busy;
  logic       sync_mode_en_q;

  assign suppress       = error_irq_suppress && st.err_flag;
  assign busy           = st.xst == XFER_SHIFT;
  assign sync_mode_en_q = chan_en;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rise_cnt <= 4'h0;
    end else if (start_xfer) begin
      rise_cnt <= 4'h0;
    end else if (busy && !st.sck && next_st.sck) begin
      rise_cnt <= rise_cnt + 4'h1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence s_start;
    !busy && wr_shift && chan_en;
  endsequence

  sequence s_done;
    busy ##1 !busy && sync_mode_en_q;
  endsequence

  property p_idle_high;
    !busy |-> st.sck;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("serial clock not high while idle");

  property p_start;
    s_start |=> busy && st.sck && rise_cnt == 4'h0;
  endproperty
  a_start: assert property (p_start)
    else $error("qualified write did not start a transfer");

  property p_no_start;
    !busy && wr_shift && !chan_en |=> !busy;
  endproperty
  a_no_start: assert property (p_no_start)
    else $error("transfer started while channel disabled");

  property p_eight_bits;
    s_done |-> rise_cnt == BITS_PER_XFER;
  endproperty
  a_eight_bits: assert property (p_eight_bits)
    else $error("transfer ended without eight bits");

  property p_flag_on_done;
    s_done |-> st.xfer_flag && st.sck;
  endproperty
  a_flag_on_done: assert property (p_flag_on_done)
    else $error("transfer flag not set at end");

  property p_so_on_fall;
    $changed(st.so) |-> $fell(st.sck);
  endproperty
  a_so_on_fall: assert property (p_so_on_fall)
    else $error("data out changed away from falling clock");

  property p_bypass_rate;
    busy && chan_en && st.baud_ctrl[3:0] == DIV_BYPASS && fsck_tick
      |=> $changed(st.sck);
  endproperty
  a_bypass_rate: assert property (p_bypass_rate)
    else $error("bypass serial clock not half the source");

  property p_rxe_abort;
    !receive_enable_bit |=> st.rx_shift_register == RX_IDLE && !st.pend && !st.cpl_irq;
  endproperty
  a_rxe_abort: assert property (p_rxe_abort)
    else $error("receiver active after enable cleared");

  property p_suppress;
    st.cpl_irq |-> !$past(suppress);
  endproperty
  a_suppress: assert property (p_suppress)
    else $error("completion raised while error suppressed");

  property p_err_then_pend;
    st.err_irq |-> st.pend && st.pend_cnt == ERR_CPL_DELAY ##1
                   !st.cpl_irq;
  endproperty
  a_err_then_pend: assert property (p_err_then_pend)
    else $error("error request not followed by delayed completion");

endmodule

/* File: verification/serial_peer.sv */
`timescale 1ns/1ps
// far-side clocked peripheral: drives data on the falling serial clock
// and samples the device's output on the rising one
module serial_peer (
  // three-wire link
  input  wire logic       sclk,
  input  wire logic       sout,
  output logic            sin,
  // byte gathered from the device
  output logic      [7:0] rx_byte
);
  logic [7:0] tx_sh;
  int         bits;

  initial begin
    sin     = 1'b1;
    rx_byte = 8'h00;
    tx_sh   = 8'h00;
    bits    = 8;
  end

  // the line flips on arming so a stale bit is never read as fresh data
  task automatic arm(input logic [7:0] b);
    tx_sh   = b;
    bits    = 0;
    rx_byte = 8'h00;
    sin     = ~sin;
  endtask

  always @(negedge sclk) begin
    if (bits < 8) begin
      sin   = tx_sh[7];
      tx_sh = {tx_sh[6:0], 1'b0};
    end
  end

  always @(posedge sclk) begin
    if (bits < 8) begin
      rx_byte = {rx_byte[6:0], sout};
      bits    = bits + 1;
      // hold is over after the eighth bit, so the line no longer means data
      if (bits == 8) begin
        #5 sin = ~sin;
      end
    end
  end
endmodule

/* File: verification/test_serial2_channel.sv */
`timescale 1ns/1ps
module test_serial2_channel
  import serial2_pkg::*;
;
  logic        core_clk  = 1'b0;
  logic        rst_b     = 1'b0;
  logic [15:0] sfr_addr  = 16'h0000;
  logic        sfr_we    = 1'b0;
  logic        sfr_re    = 1'b0;
  logic [7:0]  sfr_wdata = 8'h00;
  logic [7:0]  sfr_rdata;
  logic        osc_bit   = 1'b1;
  logic        rxd_pin   = 1'b1;
  logic        sclk;
  logic        sout;
  logic        sin;
  logic        xfer_flag;
  logic        cpl;
  int          cpl_cnt   = 0;
  logic [7:0]  peer_rx;
  logic [7:0]  rd_val;
  logic        sclk_q    = 1'b1;
  int          error_cnt = 0;
  int          checks    = 0;
  int          cyc       = 0;
  int          last_fall = 0;
  int          period    = 0;
  int          falls     = 0;
  logic [7:0]  cfg_baud [5] = '{8'h50, 8'h51, 8'h6F, 8'h5F, 8'h0F};
  logic        cfg_osc  [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
  int          cfg_per  [5] = '{32, 34, 8, 2, 2048};
  logic [15:0] reg_list [6] = '{ASYNC_MODE_ADDR, SYNC_MODE_ADDR,
                                BAUD_CTRL_ADDR, STATUS_ADDR,
                                SHIFT_DATA_ADDR, 16'hFF00};

  serial2_channel u_dut (
    .core_clk             (core_clk),
    .rst_b                (rst_b),
    .sfr_addr             (sfr_addr),
    .sfr_we               (sfr_we),
    .sfr_re               (sfr_re),
    .sfr_wdata            (sfr_wdata),
    .sfr_rdata            (sfr_rdata),
    .oscillation_mode_bit (osc_bit),
    .serial_clock_pin     (sclk),
    .serial_out_pin       (sout),
    .serial_in_pin        (sin),
    .rxd_pin              (rxd_pin),
    .transfer_irq_flag    (xfer_flag),
    .rx_complete_irq      (cpl),
    .rx_error_irq         ()
  );

  serial_peer u_peer (
    .sclk    (sclk),
    .sout    (sout),
    .sin     (sin),
    .rx_byte (peer_rx)
  );

  initial begin
    forever #25 core_clk = ~core_clk;
  end

  // sampled on the falling core edge, away from the design's updates
  always @(negedge core_clk) begin
    cyc    <= cyc + 1;
    sclk_q <= sclk;
    if (cpl === 1'b1) begin
      cpl_cnt <= cpl_cnt + 1;
    end
    if (sclk_q === 1'b1 && sclk === 1'b0) begin
      period    <= cyc - last_fall;
      last_fall <= cyc;
      falls     <= falls + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_we    <= 1'b1;
    @(posedge core_clk);
    sfr_we    <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_re   <= 1'b1;
    @(posedge core_clk);
    sfr_re   <= 1'b0;
    @(posedge core_clk);
    #1 rd_val = sfr_rdata;
  endtask

  task automatic xfer(input logic [7:0] peer_b, input logic [7:0] d);
    int n;
    u_peer.arm(peer_b);
    wr(SHIFT_DATA_ADDR, d);
    n = 0;
    while (xfer_flag !== 1'b1 && n < 20000) begin
      @(posedge core_clk);
      n++;
    end
    #1;
    check("xfer_flag", xfer_flag, 1'b1);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    foreach (reg_list[i]) begin
      rd(reg_list[i]);
      check("reset_value", rd_val, REG_RESET);
    end
    check("sclk_reset", sclk, 1'b1);
    $display("test reset done");

    wr(ASYNC_MODE_ADDR, 8'h00);
    wr(SYNC_MODE_ADDR, 8'h80);
    for (int i = 0; i < 5; i++) begin
      @(posedge core_clk);
      osc_bit <= cfg_osc[i];
      wr(BAUD_CTRL_ADDR, cfg_baud[i]);
      rd(BAUD_CTRL_ADDR);
      check("baud_ctrl", rd_val, cfg_baud[i]);
      xfer(8'h35, 8'(8'hC3 + i));
      check("sclk_period", 16'(period), 16'(cfg_per[i]));
      check("peer_rx", peer_rx, 8'(8'hC3 + i));
      check("sclk_idle", sclk, 1'b1);
      rd(STATUS_ADDR);
      check("status_done", rd_val, 8'h01);
      wr(STATUS_ADDR, 8'h00);
    end
    $display("test clock rates done");

    @(posedge core_clk);
    osc_bit <= 1'b1;
    wr(BAUD_CTRL_ADDR, 8'h50);
    xfer(8'h35, 8'h1D);
    check("peer_msb", peer_rx, 8'h1D);
    rd(SHIFT_DATA_ADDR);
    check("rx_msb", rd_val, 8'h35);
    wr(STATUS_ADDR, 8'h00);
    rd(STATUS_ADDR);
    check("flag_clear", rd_val, 8'h00);
    wr(SYNC_MODE_ADDR, 8'h84);
    xfer(8'h35, 8'h1D);
    check("peer_lsb", peer_rx, 8'hB8);
    rd(SHIFT_DATA_ADDR);
    check("rx_lsb", rd_val, 8'hAC);
    wr(STATUS_ADDR, 8'h00);
    $display("test bit order done");

    wr(SYNC_MODE_ADDR, 8'h80);
    u_peer.arm(8'h00);
    wr(SHIFT_DATA_ADDR, 8'h96);
    repeat (40) @(posedge core_clk);
    rd(STATUS_ADDR);
    check("busy", rd_val, 8'h08);
    // the second write must neither restart nor replace the data
    wr(SHIFT_DATA_ADDR, 8'h11);
    n = 0;
    while (xfer_flag !== 1'b1 && n < 20000) begin
      @(posedge core_clk);
      n++;
    end
    #1;
    check("busy_write", peer_rx, 8'h96);
    wr(STATUS_ADDR, 8'h00);
    $display("test write while busy done");

    u_peer.arm(8'h00);
    wr(SHIFT_DATA_ADDR, 8'h5A);
    repeat (80) @(posedge core_clk);
    wr(SYNC_MODE_ADDR, 8'h00);
    repeat (40) @(posedge core_clk);
    check("abort_sclk", sclk, 1'b1);
    check("abort_flag", xfer_flag, 1'b0);
    $display("test abort done");

    n = falls;
    wr(SHIFT_DATA_ADDR, 8'h77);
    wr(SYNC_MODE_ADDR, 8'h80);
    repeat (100) @(posedge core_clk);
    check("late_enable", 16'(falls - n), 16'h0000);
    check("late_flag", xfer_flag, 1'b0);
    $display("test late enable done");

    // receive one frame, two core cycles per bit
    wr(BAUD_CTRL_ADDR, 8'h5F);
    wr(ASYNC_MODE_ADDR, 8'h40);
    @(posedge core_clk);
    rxd_pin <= 1'b0;
    repeat (2) @(posedge core_clk);
    for (int b = 0; b < 8; b++) begin
      rxd_pin <= 8'hA5 >> b;
      repeat (2) @(posedge core_clk);
    end
    rxd_pin <= 1'b1;
    repeat (20) @(posedge core_clk);
    rd(RX_BUF_ADDR);
    check("rx_buf", rd_val, 8'hA5);
    check("rx_cpl", 16'(cpl_cnt), 16'h0001);
    rd(STATUS_ADDR);
    check("rx_status", rd_val, 8'h00);
    wr(ASYNC_MODE_ADDR, 8'h00);
    $display("test uart receive done");
    close_out();
  end

  initial begin
    // slowest transfer is eight bits of 2048 cycles; the rest are short
    repeat (60000) @(posedge core_clk);
    error_cnt++;
    close_out();
  end
endmodule
